// File: hw/bridge_consts.svh
// constants for the inbound word assembly bridge
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH

// ****************************************************************
// device select codes (six select lines)
// ****************************************************************
`define SEL_LOAD_LOW      6'h38
`define SEL_LOAD_MID      6'h39
`define SEL_LOAD_TOP      6'h3a
`define SEL_WIDE_HOST     6'h12

// ****************************************************************
// buffer field boundaries (highest bit of each field)
// ****************************************************************
`define FIELD_A_TOP       11
`define FIELD_B_TOP       17
`define FIELD_C_TOP       23
`define FIELD_D_TOP       35

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_STATUS        4'h0
`define REG_CHANNEL       4'h4
`define REG_DATA_LO       4'h8
`define REG_DATA_HI       4'hc

// ****************************************************************
// status field positions and reset values
// ****************************************************************
`define STAT_MODE_BIT     31
`define STAT_FULL_BIT     30
`define STAT_NOTIFY_BIT   29
`define CHAN_RESET        3'h0
`define BUF_RESET         36'h0

`endif

// File: hw/bridge_pkg.sv
// shared types of the inbound word assembly bridge
package bridge_pkg;
   typedef logic [35:0] word_type;
   typedef logic [2:0]  chan_type;
   typedef logic [5:0]  sel_type;
endpackage : bridge_pkg

// File: hw/command_select_decoder.sv
// command decoder: turns select lines and io pulses into strobes
`timescale 1ns/1ns
`include "bridge_consts.svh"
module command_select_decoder (
   // host mode
   input  wire logic              i_mode_18,
   // smaller host select and pulses
   input  wire bridge_pkg::sel_type i_select,
   input  wire logic              i_io9_qualifier,
   input  wire logic              i_io_pulse_first,
   input  wire logic              i_io_pulse_fourth,
   input  wire logic              i_subdevice_bit_zero,
   input  wire logic              i_subdevice_bit_one,
   // decoded strobes
   output logic                   o_clear,
   output logic                   o_strobe_a,
   output logic                   o_strobe_b,
   output logic                   o_strobe_c,
   output logic                   o_strobe_d,
   output logic                   o_flag_test
);

   // ****************************************************************
   // selection codes
   // ****************************************************************
   logic sel_low;
   logic sel_mid;
   logic sel_top;
   logic sel_wide;
   logic mid_pulse;

   // twelve-bit host: select lines alone pick the code
   assign sel_low  = !i_mode_18 && (i_select == `SEL_LOAD_LOW);
   assign sel_mid  = !i_mode_18 && (i_select == `SEL_LOAD_MID);
   assign sel_top  = !i_mode_18 && (i_select == `SEL_LOAD_TOP);
   // eighteen-bit host: select lines qualified by the io-9 line
   assign sel_wide = i_mode_18 && i_io9_qualifier && (i_select == `SEL_WIDE_HOST);

   // ****************************************************************
   // strobes
   // ****************************************************************
   assign mid_pulse = sel_mid && i_io_pulse_fourth;

   // clear: 70 with first pulse, or 22 with first pulse and both subdevice bits low
   assign o_clear = (sel_low && i_io_pulse_first)
                  || (sel_wide && i_io_pulse_first
                      && !i_subdevice_bit_zero && !i_subdevice_bit_one);
   assign o_strobe_a = (sel_low && i_io_pulse_fourth)
                     || (sel_wide && i_io_pulse_fourth && !i_subdevice_bit_one);
   // middle pulse splits into b and c; wide mode derives b from a
   assign o_strobe_b = mid_pulse
                     || (sel_wide && i_io_pulse_fourth && !i_subdevice_bit_one);
   assign o_strobe_c = mid_pulse
                     || (sel_wide && i_io_pulse_fourth && i_subdevice_bit_one);
   assign o_strobe_d = (sel_top && i_io_pulse_fourth)
                     || (sel_wide && i_io_pulse_fourth && i_subdevice_bit_one);
   // flag test: 71 with first pulse, or 22 with first pulse, subdevice one high and subdevice zero low
   assign o_flag_test = (sel_mid && i_io_pulse_first)
                      || (sel_wide && i_io_pulse_first
                          && i_subdevice_bit_one && !i_subdevice_bit_zero);

endmodule : command_select_decoder

// File: hw/inbound_word_assembly_bridge.sv
// inbound word assembly bridge: smaller host loads, wide host reads
//
// Summary of operation
// - in 12-bit mode, command 701 starts a transfer by emptying the buffer
// - select 70 with first pulse clears all 36 bits and the notify flag
// - command 704: host drives 12 lines, fourth pulse loads bits 00-11
// - command 714: select 71 fourth pulse splits into strobes for 12-17, 18-23
// - command 724 loads bits 24-35 and sets the full flag
// - while full, decode the channel number and raise that wide interrupt line
// - status read returns bit 30 high whenever the buffer holds data; here bit 30 is the full flag, set only by the top load
// - data read returns all 36 bits, clears full, sets notify; here the low read gives bits 00-31 and the high read the 32-35 snapshot
// - while notify is set, interrupt the smaller host
// - in 12-bit mode, flag test 711 yields a skip request
// - in 12-bit mode, selection comes from the six select lines
// - 18-bit command 2201 clears the buffer and the notify flag
// - 18-bit 2204 with subdevice one low loads bits 00-11 and 12-17
// - 18-bit routing: lines 00-11 to 00-11, 18-29; upper six to 12-17, 30-35
// - 18-bit 2224 with subdevice one high loads 18-35 and sets full
// - in 18-bit mode, flag test 2221 yields a skip request
// - in 18-bit mode, select 22 needs the io-9 qualifier line
// - reset clears the channel register; power off holds flags cleared
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "bridge_consts.svh"
module inbound_word_assembly_bridge (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // configuration and power
   input  wire logic        i_mode_18,
   input  wire logic        i_control_off,
   // smaller host io bus
   input  wire logic [5:0]  i_memory_buffer_select_lines,
   input  wire logic        i_io9_qualifier,
   input  wire logic        i_io_pulse_first,
   input  wire logic        i_io_pulse_fourth,
   input  wire logic        i_subdevice_bit_zero,
   input  wire logic        i_subdevice_bit_one,
   input  wire logic [17:0] i_io_bus_lines,
   output logic             o_interrupt_request_line,
   output logic             o_skip_request_line,
   // avalon-mm slave (wide host)
   input  wire logic [3:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   // wide host interrupt lines, one per channel
   output logic [7:0]       o_wide_interrupt_request
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   bridge_pkg::word_type buf_r;
   bridge_pkg::word_type route;
   bridge_pkg::chan_type chan_r;
   logic                 full_r;
   logic                 notify_r;
   logic [3:0]           hi_snap_r;
   logic [7:0]           pi_req_r;
   logic [31:0]          readdata_r;
   logic                 resp_r;
   logic                 clear;
   logic                 strobe_a;
   logic                 strobe_b;
   logic                 strobe_c;
   logic                 strobe_d;
   logic                 flag_test;
   logic                 accept;
   logic                 data_read;
   logic [3:0]           field_en;

   // ****************************************************************
   // command decode
   // ****************************************************************
   command_select_decoder u_decoder (
      .i_mode_18            (i_mode_18),
      .i_select             (i_memory_buffer_select_lines),
      .i_io9_qualifier      (i_io9_qualifier),
      .i_io_pulse_first     (i_io_pulse_first),
      .i_io_pulse_fourth    (i_io_pulse_fourth),
      .i_subdevice_bit_zero (i_subdevice_bit_zero),
      .i_subdevice_bit_one  (i_subdevice_bit_one),
      .o_clear              (clear),
      .o_strobe_a           (strobe_a),
      .o_strobe_b           (strobe_b),
      .o_strobe_c           (strobe_c),
      .o_strobe_d           (strobe_d),
      .o_flag_test          (flag_test)
   );

   // ****************************************************************
   // input routing and buffer
   // ****************************************************************
   // mode picks how the data lines fan out over the four fields
   always_comb begin
      if (i_mode_18) begin
         route = {i_io_bus_lines[17:12], i_io_bus_lines[11:0],
                  i_io_bus_lines[17:12], i_io_bus_lines[11:0]};
      end else begin
         route = {i_io_bus_lines[11:0], i_io_bus_lines[11:0],
                  i_io_bus_lines[11:0]};
      end
   end

   assign field_en = {strobe_d, strobe_c, strobe_b, strobe_a};

   // each bit clears on the clear pulse and loads from its field strobe
   generate
      for (genvar i = 0; i <= `FIELD_D_TOP; i++) begin : g_bit
         localparam int FIELD = (i <= `FIELD_A_TOP) ? 0 :
                                (i <= `FIELD_B_TOP) ? 1 :
                                (i <= `FIELD_C_TOP) ? 2 : 3;
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               buf_r[i] <= 1'b0;
            end else if (field_en[FIELD]) begin
               buf_r[i] <= route[i];
            end else if (clear) begin
               buf_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // bus slave: one wait state on every access
   // ****************************************************************
   assign o_waitrequest = (i_read || i_write) && !resp_r;
   assign accept        = (i_read || i_write) && resp_r;
   assign data_read     = accept && i_read && (i_address == `REG_DATA_LO);
   assign o_readdata    = readdata_r;

   // response phase flag
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         resp_r <= 1'b0;
      end else begin
         resp_r <= (i_read || i_write) && !resp_r;
      end
   end

   // read data prepared in the wait cycle, held through the accept edge
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         readdata_r <= 32'h0;
      end else if (i_read && !resp_r) begin
         unique case (i_address)
            `REG_STATUS: begin
               readdata_r <= 32'h0;
               readdata_r[`STAT_MODE_BIT]   <= i_mode_18;
               readdata_r[`STAT_FULL_BIT]   <= full_r;
               readdata_r[`STAT_NOTIFY_BIT] <= notify_r;
               readdata_r[2:0]              <= chan_r;
            end
            `REG_CHANNEL: readdata_r <= {29'h0, chan_r};
            `REG_DATA_LO: readdata_r <= buf_r[31:0];
            `REG_DATA_HI: readdata_r <= {28'h0, hi_snap_r};
            default:      readdata_r <= 32'h0;
         endcase
      end
   end

   // upper four bits captured when the low word is taken
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hi_snap_r <= 4'h0;
      end else if (data_read) begin
         hi_snap_r <= buf_r[35:32];
      end
   end

   // channel register, cleared by reset and while power is off
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         chan_r <= `CHAN_RESET;
      end else if (i_control_off) begin
         chan_r <= `CHAN_RESET;
      end else if (accept && i_write && i_address == `REG_CHANNEL && i_byteenable[0]) begin
         chan_r <= i_writedata[2:0];
      end
   end

   // ****************************************************************
   // handshake flags
   // ****************************************************************
   // full: set by top load, cleared by data read; set wins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         full_r <= 1'b0;
      end else if (i_control_off) begin
         full_r <= 1'b0;
      end else if (strobe_d) begin
         full_r <= 1'b1;
      end else if (data_read) begin
         full_r <= 1'b0;
      end
   end

   // notify: set by data read, cleared by clear pulse; set wins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         notify_r <= 1'b0;
      end else if (i_control_off) begin
         notify_r <= 1'b0;
      end else if (data_read) begin
         notify_r <= 1'b1;
      end else if (clear) begin
         notify_r <= 1'b0;
      end
   end

   // ****************************************************************
   // interrupts and skip
   // ****************************************************************
   // channel decode; channel zero disables the request
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pi_req_r <= 8'h0;
      end else begin
         pi_req_r <= (full_r && chan_r != 3'h0) ? (8'h1 << chan_r) : 8'h0;
      end
   end

   assign o_wide_interrupt_request = pi_req_r;
   assign o_interrupt_request_line = notify_r;
   assign o_skip_request_line      = flag_test && notify_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_lo_read_accept;
      i_read && !resp_r && i_address == `REG_DATA_LO ##1 data_read;
   endsequence

   sequence s_bus_request;
      (i_read || i_write) && !resp_r;
   endsequence

   chk_clear_empties: assert property (
      clear && field_en == 4'h0 && !data_read && !i_control_off
      |=> buf_r == 36'h0 && !notify_r)
      else $error("clear pulse did not empty buffer and notify");
   chk_low_load: assert property (
      strobe_a |=> buf_r[11:0] == $past(i_io_bus_lines[11:0]))
      else $error("low field not loaded from data lines");
   chk_mid_split: assert property (
      !i_mode_18 |-> strobe_b == strobe_c)
      else $error("middle load not split into both strobes");
   chk_full_set: assert property (
      strobe_d && !i_control_off |=> full_r ##1 (pi_req_r != 8'h0 || chan_r == 3'h0))
      else $error("top load did not set full");
   chk_pi_decode: assert property (
      full_r && chan_r != 3'h0 |=> pi_req_r == (8'h1 << $past(chan_r)))
      else $error("wide interrupt on wrong channel");
   chk_status_bit: assert property (
      i_read && !resp_r && i_address == `REG_STATUS
      |=> o_readdata[`STAT_FULL_BIT] == $past(full_r))
      else $error("status full bit mismatch");
   chk_data_read: assert property (
      s_lo_read_accept ##0 (!strobe_d && !i_control_off) |=> !full_r && notify_r)
      else $error("data read did not move full to notify");
   chk_route_wide: assert property (
      i_mode_18 && strobe_c
      |=> buf_r[35:18] == {$past(i_io_bus_lines[17:12]), $past(i_io_bus_lines[11:0])})
      else $error("upper half routing wrong in wide mode");
   chk_skip_gate: assert property (
      o_skip_request_line |-> notify_r && flag_test)
      else $error("skip without notify");
   chk_power_off: assert property (
      i_control_off |=> !full_r && !notify_r && chan_r == 3'h0)
      else $error("flags not held cleared while power off");
   chk_bus_wait: assert property (
      s_bus_request |-> o_waitrequest ##1 !o_waitrequest)
      else $error("bus answer not after one wait state");
   // narrow flag test decoded straight from the pins raises skip while notified
   chk_skip_narrow: assert property (
      notify_r && i_io_pulse_first && !i_mode_18
      && i_memory_buffer_select_lines == `SEL_LOAD_MID
      |-> o_skip_request_line)
      else $error("narrow flag test gave no skip while notified");
   // wide flag test decoded straight from the pins raises skip while notified
   chk_skip_wide: assert property (
      notify_r && i_io_pulse_first && i_mode_18 && i_io9_qualifier
      && i_memory_buffer_select_lines == `SEL_WIDE_HOST
      && i_subdevice_bit_one && !i_subdevice_bit_zero
      |-> o_skip_request_line)
      else $error("wide flag test gave no skip while notified");
   // without the io-9 qualifier the wide select must do nothing
   chk_qual_gate: assert property (
      i_mode_18 && !i_io9_qualifier |-> field_en == 4'h0 && !clear && !flag_test)
      else $error("wide select acted without qualifier");
   // the wide interrupt falls two cycles after the data read
   chk_irq_drop: assert property (
      data_read && !strobe_d |=> ##1 pi_req_r == 8'h0)
      else $error("wide interrupt kept after data read");
   // high snapshot keeps the top four bits seen at the data read
   chk_hi_snap: assert property (
      data_read |=> hi_snap_r == $past(buf_r[35:32]))
      else $error("upper bits not captured at data read");

endmodule : inbound_word_assembly_bridge

// File: tb/small_host_model.sv
// behavioural smaller host that issues io transfer commands to the bridge
`timescale 1ns/1ns
module small_host_model (
   // clock and skip answer
   input  wire logic        i_clk,
   input  wire logic        i_skip,
   // io bus toward the bridge
   output logic [5:0]       o_sel,
   output logic             o_q,
   output logic             o_p1,
   output logic             o_p4,
   output logic             o_sd0,
   output logic             o_sd1,
   output logic [17:0]      o_data
);
   // ***************************************************************
   // command issue
   // ***************************************************************
   // idle bus at time zero
   initial begin
      {o_sel, o_q, o_p1, o_p4, o_sd0, o_sd1, o_data} = '0;
   end

   // one command: select, qualifier, data and one pulse for one cycle
   task automatic io_transfer_command(input logic [5:0] sel, input logic q, input logic first,
                      input logic sd0, input logic sd1, input logic [17:0] d,
                      output logic skip);
      @(posedge i_clk);
      o_sel  <= sel;
      o_q    <= q;
      o_sd0  <= sd0;
      o_sd1  <= sd1;
      o_data <= d;                 // data lines driven for the load
      o_p1   <= first;
      o_p4   <= ~first;
      @(negedge i_clk);
      skip = i_skip;               // skip answer stands only in the pulse cycle
      @(posedge i_clk);
      o_p1   <= 1'b0;
      o_p4   <= 1'b0;
      o_sel  <= ~sel;              // released lines do not keep the last value
      o_data <= ~d;
   endtask : io_transfer_command
endmodule : small_host_model

// File: tb/tb_top.sv
// self-checking bench of the inbound word assembly bridge
`timescale 1ns/1ns
module tb_top;
   logic        clk, rst, mode_18, control_off, read, write, waitrequest;
   logic        q, p1, p4, sd0, sd1, irq_line, skip, skip_seen;
   logic [5:0]  sel;
   logic [17:0] data;
   logic [3:0]  address;
   logic [31:0] writedata, readdata;
   logic [7:0]  wide_irq;
   int          miscompares, n_checks, cycles;

   inbound_word_assembly_bridge inbound_word_assembly_bridge_i (
      .i_clk(clk), .i_rst(rst), .i_mode_18(mode_18), .i_control_off(control_off),
      .i_memory_buffer_select_lines(sel), .i_io9_qualifier(q), .i_io_pulse_first(p1),
      .i_io_pulse_fourth(p4), .i_subdevice_bit_zero(sd0), .i_subdevice_bit_one(sd1),
      .i_io_bus_lines(data), .o_interrupt_request_line(irq_line),
      .o_skip_request_line(skip), .i_address(address), .i_read(read), .i_write(write),
      .i_writedata(writedata), .i_byteenable(4'hf), .o_readdata(readdata),
      .o_waitrequest(waitrequest), .o_wide_interrupt_request(wide_irq));

   small_host_model small_host_model_i (
      .i_clk(clk), .i_skip(skip), .o_sel(sel), .o_q(q), .o_p1(p1), .o_p4(p4),
      .o_sd0(sd0), .o_sd1(sd1), .o_data(data));

   // ***************************************************************
   // clock, timeout and helpers
   // ***************************************************************
   initial begin
      {clk, rst, mode_18, control_off, read, write} = 6'h10;
      {address, writedata, miscompares, n_checks, cycles} = '0;
   end
   always #5 clk = ~clk;

   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      address   <= a;
      writedata <= wd;
      write     <= wr;
      read      <= ~wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic host(input logic [5:0] s, input logic qq, input logic f,
                       input logic z, input logic o, input logic [17:0] d);
      small_host_model_i.io_transfer_command(s, qq, f, z, o, d, skip_seen);
   endtask : host

   task automatic do_reset(input logic m);
      rst     <= 1'b1;
      mode_18 <= m;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // expected word from the pieces that were loaded
   function automatic logic [35:0] exp_word(logic m, logic part, logic [17:0] a,
                                            logic [17:0] b, logic [17:0] c);
      if (m) return {c, part ? 18'h0 : a};
      return {c[11:0], part ? 12'h0 : b[11:0], a[11:0]};
   endfunction : exp_word

   // one whole transfer: clear, loads, status, data read, flag test
   task automatic do_word(input logic part);
      logic [31:0] r, r2;
      logic [17:0] a, b, c;
      logic [2:0]  ch;
      a  = 18'($urandom);
      b  = 18'($urandom);
      c  = 18'($urandom);
      ch = 3'($urandom_range(7, 1));
      bus(1'b1, 4'h4, {29'h0, ch}, r);
      if (mode_18) begin
         host(6'h12, 1'b1, 1'b1, 1'b0, 1'b0, 18'h0);
         if (!part) host(6'h12, 1'b1, 1'b0, 1'b0, 1'b0, a);
         host(6'h12, 1'b0, 1'b0, 1'b0, 1'b1, c);
      end else begin
         host(6'h38, 1'b0, 1'b1, 1'b0, 1'b0, 18'h0);
         host(6'h38, 1'b0, 1'b0, 1'b0, 1'b0, a);
         if (!part) host(6'h39, 1'b0, 1'b0, 1'b0, 1'b0, b);
         host(6'h3b, 1'b0, 1'b0, 1'b0, 1'b0, c);
      end
      bus(1'b0, 4'h0, 32'h0, r);
      check("status before top load", 36'(r), {4'h0, mode_18, 28'h0, ch});
      check("notify after clear", 36'(irq_line), 36'h0);
      if (mode_18) host(6'h12, 1'b1, 1'b0, 1'b0, 1'b1, c);
      else host(6'h3a, 1'b0, 1'b0, 1'b0, 1'b0, c);
      bus(1'b0, 4'h0, 32'h0, r);
      check("status full", 36'(r[31:29]), {33'h0, mode_18, 2'b10});
      check("wide interrupt", 36'(wide_irq), 36'(8'h01 << ch));
      if (mode_18) host(6'h12, 1'b1, 1'b1, 1'b0, 1'b1, 18'h0);
      else host(6'h39, 1'b0, 1'b1, 1'b0, 1'b0, 18'h0);
      check("skip while not notified", 36'(skip_seen), 36'h0);
      bus(1'b0, 4'h8, 32'h0, r);
      bus(1'b0, 4'hc, 32'h0, r2);
      check("data word", {r2[3:0], r}, exp_word(mode_18, part, a, b, c));
      bus(1'b0, 4'h0, 32'h0, r);
      check("status after read", 36'(r[30:29]), 36'h1);
      check("wide interrupt dropped", 36'(wide_irq), 36'h0);
      check("notify line", 36'(irq_line), 36'h1);
      if (mode_18) host(6'h12, 1'b1, 1'b1, 1'b0, 1'b1, 18'h0);
      else host(6'h39, 1'b0, 1'b1, 1'b0, 1'b0, 18'h0);
      check("skip when notified", 36'(skip_seen), 36'h1);
   endtask : do_word

   // ***************************************************************
   // main sequence: each host mode in turn, each ending with power control off
   // ***************************************************************
   initial begin
      logic [31:0] r;
      void'($urandom(32'h2952b17f));
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         bus(1'b0, 4'h4, 32'h0, r);
         check("channel at reset", 36'(r), 36'h0);
         bus(1'b0, 4'h6, 32'h0, r);
         check("unmapped read", 36'(r), 36'h0);
         for (int k = 0; k < 6; k++) do_word(k == 1 ? 1'b1 : 1'($urandom));
         bus(1'b1, 4'h4, 32'h5, r);
         if (m[0]) host(6'h12, 1'b1, 1'b0, 1'b0, 1'b1, 18'h0);
         else host(6'h3a, 1'b0, 1'b0, 1'b0, 1'b0, 18'h0);
         control_off <= 1'b1;
         repeat (2) @(posedge clk);
         bus(1'b0, 4'h0, 32'h0, r);
         check("status power off", 36'(r[30:0]), 36'h0);
         check("notify power off", 36'(irq_line), 36'h0);
         check("wide interrupt power off", 36'(wide_irq), 36'h0);
         control_off <= 1'b0;
      end
      print_verdict();
   end
endmodule : tb_top
